// >>> dv/pin_partner.sv
// Pin and push-switch model for the port block
`timescale 1ns/1ps
module pin_partner (
  // Clock
  input wire logic clk,
  // Port pins
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe,
  input wire logic [4:0] pin_pullup_en,
  output logic [4:0] pin_in,
  // Push switch, pressing pulls the line low
  input wire logic press,
  output logic ext_irq_pin
);
  logic [4:0] float_q = 5'h00;
  // Undriven pins without pull-up wander every cycle
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end
  // Wire level from driver, pull-up or float
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pin_pullup_en | float_q));
  // Switch line has a pull-up
  assign ext_irq_pin = ~press;
endmodule

// >>> dv/port_pin_control_with_edge_irq_test.sv
// Self-checking bench for the port block with edge interrupt
`timescale 1ns/1ps
`include "gpio_edge_consts.svh"
module port_pin_control_with_edge_irq_test import gpio_edge_pkg::*;;
  // ==========================================================
  // Signals
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic press = 1'b0;
  logic hready, hreadyout, hresp, irq, ext_irq_pin;
  logic [31:0] hrdata, rd;
  logic [4:0] pin_in, pin_out, pin_oe, pin_pullup_en;
  logic [4:1] pin_analog_en;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] ofs [8] = '{`OFS_ANALOG_SELECT, `OFS_OUTPUT_LATCH, `OFS_DIRECTION,
    `OFS_PULLUP_SELECT, `OFS_RISE_ENABLE, `OFS_FALL_ENABLE, `OFS_REQUEST_FLAGS, `OFS_MASK_FLAGS};
  logic [7:0] rst_v [8] = '{`ANALOG_RESET, `LATCH_RESET, `DIR_RESET, `PULLUP_RESET,
    `EDGE_RESET, `EDGE_RESET, `FLAG_RESET, `MASK_RESET};
  logic [7:0] hi_v [8] = '{8'hff, 8'h1f, 8'hff, 8'h1f, 8'h01, 8'h01, 8'h02, 8'h02};
  logic [7:0] lo_v [8] = '{8'he1, 8'h00, 8'he0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  // Clock
  always #5 clk = ~clk;
  // ==========================================================
  // Instances
  gpio_edge_port u_gpio_edge_port (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .pin_analog_en(pin_analog_en), .ext_irq_pin(ext_irq_pin), .irq(irq));
  pin_partner u_pin_partner (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .pin_in(pin_in), .press(press), .ext_irq_pin(ext_irq_pin));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One single AHB-Lite transfer; read data lands in rd
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, {24'h0, d});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rd, {24'h0, e});
  endtask
  // Pin outputs after the last write has landed
  task automatic pins(input logic [18:0] e);
    #1;
    chk({13'h0, pin_analog_en, pin_pullup_en, pin_oe, pin_out}, {13'h0, e});
  endtask
  // Move the switch, then see flag and interrupt, then clear the flag
  task automatic edge_chk(input logic lvl, input logic e);
    @(posedge clk);
    press <= lvl;
    repeat (4) @(posedge clk);
    #1;
    chk({31'h0, irq}, {31'h0, e});
    rdc(`OFS_REQUEST_FLAGS, e ? 8'h02 : 8'h00);
    wr(`OFS_REQUEST_FLAGS, 8'h00);
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      final_report();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    pins({4'hf, 5'h00, 5'h00, 5'h00});
    for (int i = 0; i < 8; i++) rdc(ofs[i], rst_v[i]);
    rdc(8'h20, 8'h00);
    for (int i = 0; i < 8; i++) wr(ofs[i], 8'hff);
    for (int i = 0; i < 8; i++) rdc(ofs[i], hi_v[i]);
    // All output-capable pins made outputs
    for (int i = 0; i < 8; i++) wr(ofs[i], 8'h00);
    for (int i = 0; i < 8; i++) rdc(ofs[i], lo_v[i]);
    wr(`OFS_OUTPUT_LATCH, 8'h15);
    wr(`OFS_PULLUP_SELECT, 8'h0a);
    pins({4'h0, 5'h0a, 5'h1f, 5'h15});
    wr(`OFS_OUTPUT_LATCH, 8'h0a);
    wr(`OFS_ANALOG_SELECT, 8'h1e);
    pins({4'hf, 5'h0a, 5'h01, 5'h0a});
    wr(`OFS_DIRECTION, 8'hff);
    pins({4'hf, 5'h0a, 5'h00, 5'h0a});
    // Interrupt setup order: mask, edges, clear, unmask
    wr(`OFS_MASK_FLAGS, 8'h02);
    wr(`OFS_RISE_ENABLE, 8'h00);
    wr(`OFS_FALL_ENABLE, 8'h01);
    wr(`OFS_REQUEST_FLAGS, 8'h00);
    wr(`OFS_MASK_FLAGS, 8'h00);
    // Every edge mode against a falling then a rising edge
    for (int m = 0; m < 4; m++) begin
      wr(`OFS_RISE_ENABLE, {7'h0, m[1]});
      wr(`OFS_FALL_ENABLE, {7'h0, m[0]});
      edge_chk(1'b1, m[0]);
      edge_chk(1'b0, m[1]);
    end
    // Masked request pends without interrupt
    wr(`OFS_MASK_FLAGS, 8'h02);
    @(posedge clk);
    press <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    rdc(`OFS_REQUEST_FLAGS, 8'h02);
    wr(`OFS_MASK_FLAGS, 8'h00);
    pins({4'hf, 5'h0a, 5'h00, 5'h0a});
    chk({31'h0, irq}, 32'h1);
    wr(`OFS_REQUEST_FLAGS, 8'h00);
    #1;
    chk({31'h0, irq}, 32'h0);
    final_report();
  end
endmodule

// >>> verilog/gpio_edge_consts.svh
// Register offsets, field positions, reset values and fixed bits of the port block
`ifndef GPIO_EDGE_CONSTS_SVH
`define GPIO_EDGE_CONSTS_SVH
// ==========================================================
// Register byte offsets
`define OFS_ANALOG_SELECT 8'h00
`define OFS_OUTPUT_LATCH 8'h04
`define OFS_DIRECTION 8'h08
`define OFS_PULLUP_SELECT 8'h0c
`define OFS_RISE_ENABLE 8'h10
`define OFS_FALL_ENABLE 8'h14
`define OFS_REQUEST_FLAGS 8'h18
`define OFS_MASK_FLAGS 8'h1c
// ==========================================================
// Field positions
`define EXT_IRQ_BIT 1
`define EDGE_ENABLE_BIT 0
// ==========================================================
// Writable bit masks and fixed bit values
`define ANALOG_WMASK 8'h1e
`define ANALOG_FIXED 8'he1
`define LATCH_WMASK 8'h1f
`define DIR_WMASK 8'h1f
`define DIR_FIXED 8'he0
`define PULLUP_WMASK 8'h1f
`define EDGE_WMASK 8'h01
`define FLAG_WMASK 8'h02
// ==========================================================
// Reset values
`define ANALOG_RESET 8'hff
`define LATCH_RESET 8'h00
`define DIR_RESET 8'hff
`define PULLUP_RESET 8'h00
`define EDGE_RESET 8'h00
`define FLAG_RESET 8'h00
`define MASK_RESET 8'h02
`endif

// >>> verilog/gpio_edge_pkg.sv
// Types shared by the port block
package gpio_edge_pkg;
  // Edge qualification selected by the two enable bits
  typedef enum logic [1:0] {
    edge_none,
    edge_fall,
    edge_rise,
    edge_both
  } edge_mode_type;
endpackage

// >>> verilog/gpio_edge_port.sv
// Five-pin port with pin control and an edge-detect interrupt, on AHB-Lite
//
// Behaviour
// R1: Bits 4..1 route pin to analog path when analog-select bit is one.
// R2: Pin 0 drives its latch value when configured as output.
// R3: Direction bit zero enables output buffer; one means input mode.
// R4: Pull-up bit one connects the pin pull-up, zero leaves it off.
// R5: Rise/fall enable pair selects none, falling, rising or both edges.
// R6: Request flag sits in bit 1, one while a request pends.
// R7: Request is serviced only while its mask bit is zero.
// R8: Software masks, sets edges 00H/01H, clears flag, then unmasks.
// R9: Software sets every output-capable pin to output at start.
// R10: Interrupt pin synchronised; each qualified edge sets flag until written zero.
// R11: All control bits read and write; unimplemented bits read fixed values.
`timescale 1ns/1ps
`include "gpio_edge_consts.svh"

module gpio_edge_port
  import gpio_edge_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Port pins
  input wire logic [4:0] pin_in,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe,
  output logic [4:0] pin_pullup_en,
  output logic [4:1] pin_analog_en,
  // External interrupt pin and request
  input wire logic ext_irq_pin,
  output logic irq
);

  // ==========================================================
  // Registers
  logic [7:0] analog_q;
  logic [7:0] latch_q;
  logic [7:0] dir_q;
  logic [7:0] pullup_q;
  logic [7:0] rise_q;
  logic [7:0] fall_q;
  logic [7:0] flags_q;
  logic [7:0] mask_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic [4:0] pin_sync1_q;
  logic [4:0] pin_sync2_q;
  logic [4:0] pin_value;
  logic ext_sync1_q;
  logic ext_sync2_q;
  logic ext_prev_q;
  logic edge_hit;
  logic wr_flags;
  edge_mode_type edge_mode;

  // Merge written bits into a register, keeping fixed bits
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wmask,
                                       input logic [7:0] data);
    merge = (old & ~wmask) | (data & wmask);
  endfunction

  // Address-phase acceptance of a read or write; a write lands one cycle later
  wire addr_take = hsel && hready && htrans[1];

  // ==========================================================
  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Latch write address phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_take && hwrite;
      wr_addr_q <= haddr;
    end
  end

  // Read data captured at address phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      case (haddr)
        `OFS_ANALOG_SELECT: hrdata_q <= {24'h000000, analog_q}; // R11
        `OFS_OUTPUT_LATCH: hrdata_q <= {24'h000000, latch_q};
        `OFS_DIRECTION: hrdata_q <= {24'h000000, dir_q};
        `OFS_PULLUP_SELECT: hrdata_q <= {24'h000000, pullup_q};
        `OFS_RISE_ENABLE: hrdata_q <= {24'h000000, rise_q};
        `OFS_FALL_ENABLE: hrdata_q <= {24'h000000, fall_q};
        `OFS_REQUEST_FLAGS: hrdata_q <= {24'h000000, flags_q}; // R6
        `OFS_MASK_FLAGS: hrdata_q <= {24'h000000, mask_q};
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      analog_q <= `ANALOG_RESET;
      latch_q <= `LATCH_RESET;
      dir_q <= `DIR_RESET;
      pullup_q <= `PULLUP_RESET;
      rise_q <= `EDGE_RESET;
      fall_q <= `EDGE_RESET;
      mask_q <= `MASK_RESET;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        `OFS_ANALOG_SELECT: analog_q <= merge(analog_q, `ANALOG_WMASK, hwdata[7:0]); // R11
        `OFS_OUTPUT_LATCH: latch_q <= merge(latch_q, `LATCH_WMASK, hwdata[7:0]);
        `OFS_DIRECTION: dir_q <= merge(dir_q, `DIR_WMASK, hwdata[7:0]);
        `OFS_PULLUP_SELECT: pullup_q <= merge(pullup_q, `PULLUP_WMASK, hwdata[7:0]);
        `OFS_RISE_ENABLE: rise_q <= merge(rise_q, `EDGE_WMASK, hwdata[7:0]);
        `OFS_FALL_ENABLE: fall_q <= merge(fall_q, `EDGE_WMASK, hwdata[7:0]);
        `OFS_MASK_FLAGS: mask_q <= merge(mask_q, `FLAG_WMASK, hwdata[7:0]);
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Pin outputs
  assign pin_oe = ~dir_q[4:0] & ~{analog_q[4:1], 1'b0}; // R3 R1
  assign pin_out = latch_q[4:0]; // R2
  assign pin_pullup_en = pullup_q[4:0]; // R4
  assign pin_analog_en = analog_q[4:1]; // R1

  // Pin input synchronisers; pin_value feeds no register read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_sync1_q <= 5'h00;
      pin_sync2_q <= 5'h00;
    end else begin
      pin_sync1_q <= pin_in;
      pin_sync2_q <= pin_sync1_q;
    end
  end
  assign pin_value = pin_sync2_q;

  // ==========================================================
  // External interrupt edge detection, reset to the pulled-up idle level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_sync1_q <= 1'b1;
      ext_sync2_q <= 1'b1;
      ext_prev_q <= 1'b1;
    end else begin
      ext_sync1_q <= ext_irq_pin; // R10
      ext_sync2_q <= ext_sync1_q;
      ext_prev_q <= ext_sync2_q;
    end
  end

  // Edge mode from the enable pair
  assign edge_mode = edge_mode_type'({rise_q[`EDGE_ENABLE_BIT], fall_q[`EDGE_ENABLE_BIT]});

  // Qualify edge by mode
  always_comb begin
    case (edge_mode) // R5
      edge_none: edge_hit = 1'b0;
      edge_fall: edge_hit = ext_prev_q && !ext_sync2_q;
      edge_rise: edge_hit = !ext_prev_q && ext_sync2_q;
      edge_both: edge_hit = ext_prev_q != ext_sync2_q;
      default: edge_hit = 1'b0;
    endcase
  end

  assign wr_flags = wr_pend_q && (wr_addr_q == `OFS_REQUEST_FLAGS);

  // Request flag: set wins over software write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags_q <= `FLAG_RESET;
    end else if (edge_hit) begin
      flags_q[`EXT_IRQ_BIT] <= 1'b1; // R10 R6
    end else if (wr_flags) begin
      flags_q <= merge(flags_q, `FLAG_WMASK, hwdata[7:0]);
    end
  end

  // Level interrupt while unmasked request pends
  assign irq = flags_q[`EXT_IRQ_BIT] && !mask_q[`EXT_IRQ_BIT]; // R7

  // ==========================================================
  // Assertions
  a_fall_sets_flag: assert property (@(posedge clk) disable iff (reset)
    (edge_mode == edge_fall && $fell(ext_sync2_q))
      |=> flags_q[`EXT_IRQ_BIT]) // R5
    else $error("falling edge did not set request flag");
  a_rise_ignored: assert property (@(posedge clk) disable iff (reset)
    (edge_mode == edge_fall && $rose(ext_sync2_q) && !flags_q[`EXT_IRQ_BIT] && !wr_flags)
      |=> !flags_q[`EXT_IRQ_BIT]) // R5
    else $error("rising edge set flag in falling mode");
  a_none_no_set: assert property (@(posedge clk) disable iff (reset)
    (edge_mode == edge_none && !flags_q[`EXT_IRQ_BIT]) |=> !flags_q[`EXT_IRQ_BIT]) // R5
    else $error("flag set with detection disabled");
  sequence s_pin_fall;
    !ext_sync1_q ##1 !ext_sync1_q;
  endsequence
  a_pin_to_flag: assert property (@(posedge clk) disable iff (reset)
    (edge_mode == edge_both && ext_sync2_q && !ext_sync1_q) ##0 s_pin_fall
      |-> ##1 flags_q[`EXT_IRQ_BIT]) // R10
    else $error("pin edge not flagged within two cycles");
  a_flag_sticky: assert property (@(posedge clk) disable iff (reset)
    flags_q[`EXT_IRQ_BIT] && !wr_flags |=> flags_q[`EXT_IRQ_BIT]) // R10
    else $error("request flag dropped without write");
  a_irq_masked: assert property (@(posedge clk) disable iff (reset)
    mask_q[`EXT_IRQ_BIT] |-> !irq) // R7
    else $error("interrupt raised while masked");
  a_irq_pending: assert property (@(posedge clk) disable iff (reset)
    flags_q[`EXT_IRQ_BIT] && !mask_q[`EXT_IRQ_BIT] |-> irq) // R7
    else $error("unmasked request not raised");
  a_oe_direction: assert property (@(posedge clk) disable iff (reset)
    $fell(dir_q[0]) |-> pin_oe[0] && (pin_out[0] == latch_q[0])) // R3
    else $error("pin zero not driven after output select");
  a_analog_off: assert property (@(posedge clk) disable iff (reset)
    analog_q[2] |-> !pin_oe[2] && pin_analog_en[2]) // R1
    else $error("analog pin driven digitally");
  a_pullup_follow: assert property (@(posedge clk) disable iff (reset)
    wr_pend_q && wr_addr_q == `OFS_PULLUP_SELECT
      |=> pin_pullup_en == $past(hwdata[4:0])) // R4
    else $error("pull-up select not applied");
  a_fixed_bits: assert property (@(posedge clk) disable iff (reset)
    dir_q[7:5] == 3'h7 && analog_q[0] && latch_q[7:5] == 3'h0) // R11
    else $error("fixed register bits changed");

  // ==========================================================
  // Bus access assertions

  // Zero wait, always OKAY
  a_bus_okay: assert property (@(posedge clk) disable iff (reset)
    hreadyout && !hresp)
    else $error("bus answer not ready or not OKAY");

  // Flag read returns the flag of the address phase
  a_read_flags: assert property (@(posedge clk) disable iff (reset) // R6
    addr_take && !hwrite && haddr == `OFS_REQUEST_FLAGS |=> hrdata[1] == $past(flags_q[1]))
    else $error("request flag read wrong");

  // Unmapped reads return zero
  a_read_unmapped: assert property (@(posedge clk) disable iff (reset) // R11
    addr_take && !hwrite && haddr[7:5] != 3'h0 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Only the low byte carries data
  a_read_upper_zero: assert property (@(posedge clk) disable iff (reset) // R11
    hrdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  // Mask bit follows its write
  a_mask_write: assert property (@(posedge clk) disable iff (reset) // R7
    wr_pend_q && wr_addr_q == `OFS_MASK_FLAGS |=> mask_q[1] == $past(hwdata[1]))
    else $error("mask write not applied");

  // Direction bits follow their write
  a_direction_write: assert property (@(posedge clk) disable iff (reset) // R3
    wr_pend_q && wr_addr_q == `OFS_DIRECTION |=> dir_q[4:0] == $past(hwdata[4:0]))
    else $error("direction write not applied");

  // Analog select bits follow their write
  a_analog_write: assert property (@(posedge clk) disable iff (reset) // R1
    wr_pend_q && wr_addr_q == `OFS_ANALOG_SELECT |=> analog_q[4:1] == $past(hwdata[4:1]))
    else $error("analog select write not applied");

  // Latch bits follow their write
  a_latch_write: assert property (@(posedge clk) disable iff (reset) // R2
    wr_pend_q && wr_addr_q == `OFS_OUTPUT_LATCH |=> latch_q[4:0] == $past(hwdata[4:0]))
    else $error("latch write not applied");

  // ==========================================================
  // Pin control assertions

  // Analog pins never drive digitally
  a_oe_analog_bits: assert property (@(posedge clk) disable iff (reset) // R1
    (pin_oe[4:1] & analog_q[4:1]) == 4'h0)
    else $error("analog pin has output enabled");

  // Analog routing mirrors the select bits
  a_analog_route: assert property (@(posedge clk) disable iff (reset) // R1
    pin_analog_en == analog_q[4:1])
    else $error("analog routing differs from select");

  // Pin zero drives its latch value
  a_latch_drive: assert property (@(posedge clk) disable iff (reset) // R2
    pin_out[0] == latch_q[0])
    else $error("pin zero level differs from latch");

  // Pin zero buffer on exactly when direction is zero
  a_dir_buffer: assert property (@(posedge clk) disable iff (reset) // R3
    pin_oe[0] == !dir_q[0])
    else $error("pin zero buffer differs from direction");

  // Pull-up enables mirror the select bits
  a_pullup_map: assert property (@(posedge clk) disable iff (reset) // R4
    pin_pullup_en == pullup_q[4:0])
    else $error("pull-up enable differs from select");

  // ==========================================================
  // Edge and flag assertions

  // Rising edge sets flag in rising mode
  a_rise_sets: assert property (@(posedge clk) disable iff (reset) // R5
    edge_mode == edge_rise && $rose(ext_sync2_q) |=> flags_q[`EXT_IRQ_BIT])
    else $error("rising edge did not set request flag");

  // Any edge sets flag in both-edge mode
  a_both_sets: assert property (@(posedge clk) disable iff (reset) // R5
    edge_mode == edge_both && ($rose(ext_sync2_q) || $fell(ext_sync2_q))
      |=> flags_q[`EXT_IRQ_BIT])
    else $error("edge not flagged in both-edge mode");

  // Pin held high two samples after a rise
  sequence s_pin_rise;
    ext_sync1_q ##1 ext_sync1_q;
  endsequence

  // Rising pin reaches the flag through the synchroniser
  a_rise_pin_flag: assert property (@(posedge clk) disable iff (reset) // R10
    (edge_mode == edge_rise && !ext_sync2_q && ext_sync1_q) ##0 s_pin_rise
      |-> ##1 flags_q[`EXT_IRQ_BIT])
    else $error("rising pin not flagged within two cycles");

  // Writing zero clears the flag when no edge competes
  a_flag_clear: assert property (@(posedge clk) disable iff (reset) // R10
    wr_flags && !hwdata[1] && !edge_hit |=> !flags_q[`EXT_IRQ_BIT])
    else $error("request flag not cleared by write");

  // Unused flag and mask bits stay zero
  a_flag_fixed: assert property (@(posedge clk) disable iff (reset) // R11
    flags_q[7:2] == 6'h00 && !flags_q[0] && mask_q[7:2] == 6'h00 && !mask_q[0])
    else $error("fixed flag or mask bits changed");

endmodule
